// >>> core/qmcs_core.sv
// Control, status and serial management logic of a pluggable module.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Fully functional within bounded init time
// - Reset only after low beyond 2 us
// - Serial answers only once init done
// - Data-not-ready clears, alert asserts after init
// - Reset release restarts init, bounded time
// - Low-power pin lowers power quickly
// - Any unmasked condition pulls alert low quickly
// - Read clears flags, alert then releases
// - Read clears take effect at stop
// - Receive loss sets flag and alert
// - Other conditions set flag and alert
// - Set mask blocks flag from alert
// - Cleared mask lets flag alert again
// - Select asserted lets bus answer
// - Select deasserted silences the bus
// - Power-down bit enters low power
// - Cleared power-down bit restores full power
// - Written settings act from the byte's acknowledge, before the stop
// - Ready shown by alert plus cleared bit
// - Answers at seven-bit address 1010000
// - Page select byte at 127 writable
module qmcs_core
  import qmcs_pkg::*;
#(
  parameter int INIT_WAIT_US = 1000
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_bus_clk,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_sda,
  output var  logic        o_sda_oe,
  input  wire logic        i_bus_select_n,
  input  wire logic        i_module_reset_n,
  input  wire logic        i_low_power_request,
  input  wire logic [3:0]  i_rx_los,
  input  wire logic [3:0]  i_tx_fault,
  input  wire logic [15:0] i_misc_cond,
  output var  logic        o_host_alert_n,
  output var  logic        o_presence_n,
  output var  logic        o_low_power,
  output var  logic        o_ready,
  output var  logic        o_data_not_ready
);

  // Reference clock domain.

  logic [1:0]       pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic [6:0]       rlow_cnt_q;
  logic             soft_rst;
  logic [4:0]       tick_cnt_q;
  logic             tick;
  qmcs_pwr_e        pwr_st_q;
  logic [31:0]      init_cnt_q;
  logic             ready, ready_d_q, ready_alert_q;
  logic [NFLAG-1:0] cond, flags_q, clr_bits;
  logic [NFLAG-1:0] mask_s1_q, mask_s2_q;
  logic             pd_s1_q, pd_s2_q;
  logic             tgl_s1_q, tgl_s2_q, tgl_s3_q, clr_evt;
  logic             alert_n_q, lp_q, dnr_q;

  // Bus clock domain.

  logic [2:0]       bs1_q, bs2_q, bs3_q, bf_q;
  logic             scl_f, sda_f, sel_n_f, prev_scl_q, prev_sda_q;
  logic             scl_rise, scl_fall, start, stop, selected;
  logic [NFLAG-1:0] flags_b1_q, flags_b2_q, mask_q;
  logic             rdy_b1_q, rdy_b2_q;
  qmcs_bus_e        bst_q;
  logic [7:0]       sh_q, ptr_q, ctrl_q, page_q, rd_data;
  logic [3:0]       cnt_q;
  logic             rw_q, first_q, ack_q, sda_oe_q;
  logic             wr_stb, rd_load;
  logic [NFLAG:0]   clr_rd, clr_acc_q, clr_hold_q;
  logic             clr_tgl_q;

  assign o_presence_n = 1'b0;
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_q;
  assign o_host_alert_n = alert_n_q;
  assign o_low_power = lp_q;
  assign o_ready = ready;
  assign o_data_not_ready = dnr_q;

  // A pin change is accepted only once the second and third stages agree.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= 2'h1;
      pin_s2_q <= 2'h1;
      pin_s3_q <= 2'h1;
      pin_f_q <= 2'h1;
    end else begin
      pin_s1_q <= {i_low_power_request, i_module_reset_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rlow_cnt_q <= 7'h00;
    end else if (pin_f_q[0]) begin
      rlow_cnt_q <= 7'h00;
    end else if (rlow_cnt_q <= 7'(RST_PULSE_CYC)) begin
      rlow_cnt_q <= rlow_cnt_q + 7'h01;
    end
  end
  assign soft_rst = rlow_cnt_q > 7'(RST_PULSE_CYC);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 5'h00;
    end else if (tick) begin
      tick_cnt_q <= 5'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
    end
  end
  assign tick = tick_cnt_q == TICK_LAST;

  // Init holds while the reset pin stays low and restarts on release.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_st_q <= PW_INIT;
      init_cnt_q <= 32'h0;
    end else if (soft_rst) begin
      pwr_st_q <= PW_INIT;
      init_cnt_q <= 32'h0;
    end else begin
      case (pwr_st_q)
        PW_INIT: begin
          if (tick) begin
            if (init_cnt_q >= 32'(INIT_WAIT_US - 1)) begin
              pwr_st_q <= PW_READY;
            end else begin
              init_cnt_q <= init_cnt_q + 32'h1;
            end
          end
        end
        PW_READY: begin
          pwr_st_q <= PW_READY;
        end
        default: begin
          pwr_st_q <= PW_INIT;
        end
      endcase
    end
  end
  assign ready = pwr_st_q == PW_READY;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_s1_q <= MASK_RST;
      mask_s2_q <= MASK_RST;
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      mask_s1_q <= mask_q;
      mask_s2_q <= mask_s1_q;
      pd_s1_q <= ctrl_q[FLD_PDOWN];
      pd_s2_q <= pd_s1_q;
      tgl_s1_q <= clr_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end
  // The held clear word is stable long before its toggle arrives here.
  assign clr_evt = tgl_s2_q ^ tgl_s3_q;
  assign clr_bits = clr_evt ? clr_hold_q[NFLAG-1:0] : '0;
  assign cond = {i_misc_cond, i_tx_fault, i_rx_los};

  // Set wins over a clear that lands in the same cycle.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= '0;
    end else if (!ready) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr_bits) | cond;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ready_d_q <= 1'b0;
      ready_alert_q <= 1'b0;
    end else begin
      ready_d_q <= ready;
      if (!ready) begin
        ready_alert_q <= 1'b0;
      end else if (!ready_d_q) begin
        ready_alert_q <= 1'b1;
      end else if (clr_evt && clr_hold_q[CLR_READY]) begin
        ready_alert_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      alert_n_q <= 1'b1;
      lp_q <= 1'b0;
      dnr_q <= 1'b1;
    end else begin
      alert_n_q <= ~(ready & ((|(flags_q & ~mask_s2_q)) | ready_alert_q));
      lp_q <= pin_f_q[1] | pd_s2_q;
      dnr_q <= ~ready;
    end
  end

  // Serial bus lines and select, sampled on the bus clock.
  always_ff @(posedge i_bus_clk or posedge i_rst) begin
    if (i_rst) begin
      bs1_q <= 3'h7;
      bs2_q <= 3'h7;
      bs3_q <= 3'h7;
      bf_q <= 3'h7;
      prev_scl_q <= 1'b1;
      prev_sda_q <= 1'b1;
      flags_b1_q <= '0;
      flags_b2_q <= '0;
      rdy_b1_q <= 1'b0;
      rdy_b2_q <= 1'b0;
    end else begin
      bs1_q <= {i_bus_select_n, i_sda, i_scl};
      bs2_q <= bs1_q;
      bs3_q <= bs2_q;
      bf_q <= (bs2_q & bs3_q) | (bf_q & (bs2_q ^ bs3_q));
      prev_scl_q <= scl_f;
      prev_sda_q <= sda_f;
      flags_b1_q <= flags_q;
      flags_b2_q <= flags_b1_q;
      rdy_b1_q <= ready;
      rdy_b2_q <= rdy_b1_q;
    end
  end
  assign scl_f = bf_q[0];
  assign sda_f = bf_q[1];
  assign sel_n_f = bf_q[2];
  assign scl_rise = scl_f & ~prev_scl_q;
  assign scl_fall = ~scl_f & prev_scl_q;
  assign start = scl_f & prev_scl_q & prev_sda_q & ~sda_f;
  assign stop = scl_f & prev_scl_q & ~prev_sda_q & sda_f;
  assign selected = ~sel_n_f & rdy_b2_q;

  always_comb begin
    rd_data = 8'h00;
    clr_rd = '0;
    if (ptr_q == OFS_STATUS) begin
      rd_data[FLD_DNR] = ~rdy_b2_q;
      clr_rd[CLR_READY] = 1'b1;
    end
    for (int i = 0; i < NFLAG_BYTES; i++) begin
      if (ptr_q == OFS_FLAG0 + 8'(i)) begin
        rd_data = flags_b2_q[i*8 +: 8];
        clr_rd[i*8 +: 8] = flags_b2_q[i*8 +: 8];
      end
      if (ptr_q == OFS_MASK0 + 8'(i)) begin
        rd_data = mask_q[i*8 +: 8];
      end
    end
    if (ptr_q == OFS_CTRL) begin
      rd_data = ctrl_q;
    end
    if (ptr_q == OFS_PAGE) begin
      rd_data = page_q;
    end
  end

  assign wr_stb = selected & ~start & ~stop & (bst_q == B_WR) & scl_fall & (cnt_q == 4'h8) & ~first_q;
  assign rd_load = selected & ~start & ~stop & scl_fall &
                   (((bst_q == B_AACK) & rw_q) | ((bst_q == B_RACK) & ack_q));

  always_ff @(posedge i_bus_clk or posedge i_rst) begin
    if (i_rst) begin
      bst_q <= B_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (!selected) begin
      bst_q <= B_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start) begin
      bst_q <= B_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop) begin
      bst_q <= B_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (bst_q)
        B_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              bst_q <= B_AACK;
              sda_oe_q <= 1'b1;
              rw_q <= sh_q[0];
            end else begin
              bst_q <= B_IDLE;
            end
          end
        end
        B_AACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              bst_q <= B_RD;
              sh_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
            end else begin
              bst_q <= B_WR;
              sda_oe_q <= 1'b0;
              first_q <= 1'b1;
            end
          end
        end
        B_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            bst_q <= B_WACK;
            sda_oe_q <= 1'b1;
            first_q <= 1'b0;
            ptr_q <= first_q ? sh_q : ptr_q + 8'h01;
          end
        end
        B_WACK: begin
          if (scl_fall) begin
            bst_q <= B_WR;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
          end
        end
        B_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              bst_q <= B_RACK;
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        B_RACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_f;
          end else if (scl_fall) begin
            cnt_q <= 4'h0;
            if (ack_q) begin
              bst_q <= B_RD;
              sh_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
            end else begin
              bst_q <= B_IDLE;
            end
          end
        end
        default: begin
          bst_q <= B_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Writes land at the byte's acknowledge, well before the stop edge.
  always_ff @(posedge i_bus_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
      page_q <= PAGE_RST;
    end else if (wr_stb) begin
      if (ptr_q == OFS_CTRL) begin
        ctrl_q <= sh_q;
      end
      if (ptr_q == OFS_PAGE) begin
        page_q <= sh_q;
      end
      for (int i = 0; i < NFLAG_BYTES; i++) begin
        if (ptr_q == OFS_MASK0 + 8'(i)) begin
          mask_q[i*8 +: 8] <= sh_q;
        end
      end
    end
  end

  // Only bits that read as one are cleared, so a later event survives.
  always_ff @(posedge i_bus_clk or posedge i_rst) begin
    if (i_rst) begin
      clr_acc_q <= '0;
      clr_hold_q <= '0;
      clr_tgl_q <= 1'b0;
    end else if (stop && clr_acc_q != '0) begin
      clr_hold_q <= clr_acc_q;
      clr_tgl_q <= ~clr_tgl_q;
      clr_acc_q <= '0;
    end else if (rd_load) begin
      clr_acc_q <= clr_acc_q | clr_rd;
    end
  end

  sequence clr_all_s;
    clr_evt && (flags_q & ~clr_bits) == '0 && cond == '0 && !ready_alert_q && ready;
  endsequence

  rst_short_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pin_f_q[0] |=> !soft_rst) else $error("reset taken while pin high");
  rst_long_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!pin_f_q[0] && rlow_cnt_q == 7'(RST_PULSE_CYC)) |=> soft_rst ##1 (pwr_st_q == PW_INIT))
    else $error("long reset pulse not taken");
  init_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (pwr_st_q == PW_INIT && $past(pwr_st_q) == PW_INIT) |-> o_host_alert_n)
    else $error("alert during init");
  ready_show_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ready && !ready_d_q) |-> ##2 (!o_host_alert_n && !o_data_not_ready))
    else $error("ready not signalled");
  los_alert_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ready && i_rx_los != 4'h0 && mask_s2_q[3:0] == 4'h0) ##1 (ready && mask_s2_q[3:0] == 4'h0)
    |=> !o_host_alert_n) else $error("loss did not alert");
  flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (flags_q[0] && !clr_evt) ##1 ready |-> flags_q[0]) else $error("flag dropped unread");
  mask_block_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((flags_q & ~mask_s2_q) == '0 && !ready_alert_q) |=> o_host_alert_n)
    else $error("masked flag alerted");
  clr_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    clr_all_s ##1 (cond == '0 && ready) |=> o_host_alert_n) else $error("alert not released");
  lp_pin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_low_power_request [*6] |-> o_low_power) else $error("low power late");
  pd_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!pd_s2_q && !pin_f_q[1]) |=> !o_low_power) else $error("low power stuck");
  desel_a: assert property (@(posedge i_bus_clk) disable iff (i_rst)
    sel_n_f |=> (bst_q == B_IDLE && !sda_oe_q)) else $error("answered while deselected");
  addr_ack_a: assert property (@(posedge i_bus_clk) disable iff (i_rst)
    (bst_q == B_ADDR && scl_fall && cnt_q == 4'h8 && selected && !start && !stop && sh_q[7:1] == DEV_ADDR)
    |=> (bst_q == B_AACK && sda_oe_q)) else $error("own address not acknowledged");
  stop_clr_a: assert property (@(posedge i_bus_clk) disable iff (i_rst)
    (stop && clr_acc_q != '0) |=> (clr_tgl_q != $past(clr_tgl_q))) else $error("clear not sent");
  page_wr_a: assert property (@(posedge i_bus_clk) disable iff (i_rst)
    (wr_stb && ptr_q == OFS_PAGE) |=> page_q == $past(sh_q)) else $error("page write lost");

endmodule : qmcs_core
`default_nettype wire

// >>> core/qmcs_pkg.sv
// Constants and types for the module control and status core.
`default_nettype none
package qmcs_pkg;
  localparam int CLK_MHZ = 25;
  localparam int T_RST_PULSE_US = 2;
  localparam int RST_PULSE_CYC = T_RST_PULSE_US * CLK_MHZ;
  localparam int T_INIT_MS = 2000;
  localparam int INIT_MAX_US = T_INIT_MS * 1000;
  localparam logic [4:0] TICK_LAST = 5'(CLK_MHZ - 1);
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_FLAG0 = 8'h03;
  localparam logic [7:0] OFS_CTRL = 8'h5d;
  localparam logic [7:0] OFS_MASK0 = 8'h64;
  localparam logic [7:0] OFS_PAGE = 8'h7f;
  localparam int FLD_DNR = 0;
  localparam int FLD_PDOWN = 1;
  localparam int NFLAG_BYTES = 3;
  localparam int NFLAG = NFLAG_BYTES * 8;
  localparam int CLR_READY = NFLAG;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [NFLAG-1:0] MASK_RST = 24'h000000;

  typedef enum logic [1:0] {
    PW_INIT  = 2'b01,
    PW_READY = 2'b10
  } qmcs_pwr_e;

  typedef enum logic [6:0] {
    B_IDLE = 7'h01,
    B_ADDR = 7'h02,
    B_AACK = 7'h04,
    B_WR   = 7'h08,
    B_WACK = 7'h10,
    B_RD   = 7'h20,
    B_RACK = 7'h40
  } qmcs_bus_e;
endpackage : qmcs_pkg
`default_nettype wire

// >>> verif/qmcs_host_model.sv
// Host board controller model: two-wire master on an open-drain data line.
`timescale 1ns/1ns
`default_nettype none
module qmcs_host_model
  import qmcs_pkg::*;
#(
  parameter int HALF = 10
) (
  input  wire logic i_bus_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic half_bit();
    repeat (HALF) @(posedge i_bus_clk);
  endtask : half_bit

  // Data never moves in the cycle the clock falls, so the filtered pins cannot fake a start or stop.
  task automatic start_cond();
    half_bit();
    o_sda_low <= 1'b0;
    half_bit();
    o_scl <= 1'b1;
    half_bit();
    o_sda_low <= 1'b1;
    half_bit();
    o_scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    half_bit();
    o_sda_low <= 1'b1;
    half_bit();
    o_scl <= 1'b1;
    half_bit();
    o_sda_low <= 1'b0;
    half_bit();
  endtask : stop_cond

  task automatic bit_io(input logic b, output logic r);
    repeat (HALF / 2) @(posedge i_bus_clk);
    o_sda_low <= ~b;
    repeat (HALF / 2) @(posedge i_bus_clk);
    o_scl <= 1'b1;
    half_bit();
    r = i_sda;
    o_scl <= 1'b0;
  endtask : bit_io

  // The ninth slot is always released: it reads the device acknowledge or ends a read.
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask : byte_io

  task automatic access(input logic [6:0] dev, input logic wr, input logic [7:0] ofs,
                        input logic [7:0] wd, output logic [7:0] rd, output logic ack);
    logic [7:0] q;
    logic       a0, a1, a2, ad;
    start_cond();
    byte_io({dev, 1'b0}, q, a0);
    byte_io(ofs, q, a1);
    rd = 8'h00;
    if (wr) begin
      byte_io(wd, q, a2);
    end else begin
      start_cond();
      byte_io({dev, 1'b1}, q, a2);
      byte_io(8'hff, rd, ad);
    end
    ack = a0 & a1 & a2;
    stop_cond();
  endtask : access
endmodule : qmcs_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the module control and status core.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import qmcs_pkg::*;
  localparam logic [7:0] PD = 8'h01 << FLD_PDOWN;
  logic        ref_clk = 1'b0;
  logic        bus_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        sel_n   = 1'b1;
  logic        mrst_n  = 1'b1;
  logic        lp_req  = 1'b0;
  logic [23:0] cond    = 24'h000000;
  logic [23:0] m_flag  = 24'h000000;
  logic [31:0] rng     = 32'h7596;
  logic [7:0]  rd;
  logic        ack;
  wire         scl, host_low, sda_o, sda_oe, sda_w, alert_n, pres_n, low_pw, rdy, dnr;
  int          fails     = 0;
  int          cmp_count = 0;
  int          bitn;

  assign sda_w = ~(host_low | (sda_oe & ~sda_o));
  always #20 ref_clk = ~ref_clk;
  // The link clock has a period of its own, and its rising edges never meet those of the main clock.
  always #40 bus_clk = ~bus_clk;

  qmcs_core #(.INIT_WAIT_US(2)) dut_u (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_bus_clk(bus_clk), .i_scl(scl), .i_sda(sda_w),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_bus_select_n(sel_n), .i_module_reset_n(mrst_n),
    .i_low_power_request(lp_req), .i_rx_los(cond[3:0]), .i_tx_fault(cond[7:4]),
    .i_misc_cond(cond[23:8]), .o_host_alert_n(alert_n), .o_presence_n(pres_n),
    .o_low_power(low_pw), .o_ready(rdy), .o_data_not_ready(dnr));

  qmcs_host_model host_u (.i_bus_clk(bus_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic wait_al(input logic v, input int n);
    for (int c = 0; c < n && alert_n !== v; c++) @(posedge ref_clk);
  endtask : wait_al

  task automatic wait_rdy();
    for (int c = 0; c < 500 && rdy !== 1'b1; c++) begin
      @(posedge ref_clk);
      chk(alert_n, 1'b1);
    end
  endtask : wait_rdy

  task automatic acc(input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
    host_u.access(DEV_ADDR, wr, ofs, wd, rd, ack);
    repeat (4) @(posedge ref_clk);
  endtask : acc

  // Two cycles of condition are enough to latch; the flag must outlive it.
  task automatic pulse(input int b);
    cond[b] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cond[b] <= 1'b0;
    m_flag[b] = 1'b1;
  endtask : pulse

  // About two dozen serial accesses of under 70 us each, with roughly as much again as margin.
  initial begin
    #3000000;
    fails++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    chk({alert_n, dnr, low_pw, rdy}, 4'b1100);
    rst <= 1'b0;
    wait_rdy();
    chk(rdy, 1'b1);
    wait_al(1'b0, 20);
    chk({alert_n, dnr, pres_n}, 3'b000);
    $display("Test init done");
    acc(1'b0, OFS_STATUS, 8'h00);
    chk(ack, 1'b0);
    sel_n <= 1'b0;
    repeat (50) @(posedge ref_clk);
    host_u.access(7'h51, 1'b0, OFS_STATUS, 8'h00, rd, ack);
    chk(ack, 1'b0);
    acc(1'b0, OFS_STATUS, 8'h00);
    chk({ack, rd}, 9'h100);
    wait_al(1'b1, 50);
    chk(alert_n, 1'b1);
    $display("Test select done");
    for (int i = 0; i < 5; i++) begin
      rng = xs(rng);
      bitn = (i == 0) ? 0 : int'(rng % 24);
      pulse(bitn);
      wait_al(1'b0, 20);
      chk(alert_n, 1'b0);
      repeat (30) @(posedge ref_clk);
      chk(alert_n, 1'b0);
      acc(1'b0, OFS_FLAG0 + 8'(bitn / 8), 8'h00);
      chk(rd, m_flag[bitn / 8 * 8 +: 8]);
      m_flag = 24'h000000;
      wait_al(1'b1, 50);
      chk(alert_n, 1'b1);
      acc(1'b0, OFS_FLAG0 + 8'(bitn / 8), 8'h00);
      chk(rd, 8'h00);
    end
    $display("Test flags done");
    acc(1'b1, OFS_MASK0 + 8'h01, 8'h02);
    acc(1'b0, OFS_MASK0 + 8'h01, 8'h00);
    chk(rd, 8'h02);
    pulse(9);
    repeat (40) @(posedge ref_clk);
    chk(alert_n, 1'b1);
    acc(1'b1, OFS_MASK0 + 8'h01, 8'h00);
    wait_al(1'b0, 20);
    chk(alert_n, 1'b0);
    acc(1'b0, OFS_FLAG0 + 8'h01, 8'h00);
    chk(rd, m_flag[15:8]);
    wait_al(1'b1, 50);
    chk(alert_n, 1'b1);
    $display("Test mask done");
    lp_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(low_pw, 1'b1);
    lp_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(low_pw, 1'b0);
    acc(1'b1, OFS_CTRL, PD);
    chk(low_pw, 1'b1);
    acc(1'b0, OFS_CTRL, 8'h00);
    chk(rd, PD);
    acc(1'b1, OFS_CTRL, 8'h00);
    chk(low_pw, 1'b0);
    acc(1'b1, OFS_PAGE, 8'h03);
    acc(1'b0, OFS_PAGE, 8'h00);
    chk(rd, 8'h03);
    acc(1'b0, 8'h80, 8'h00);
    chk({ack, rd}, 9'h100);
    $display("Test power and page done");
    mrst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    mrst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(rdy, 1'b1);
    mrst_n <= 1'b0;
    repeat (120) @(posedge ref_clk);
    chk({rdy, dnr, alert_n}, 3'b011);
    acc(1'b0, OFS_STATUS, 8'h00);
    chk(ack, 1'b0);
    mrst_n <= 1'b1;
    wait_rdy();
    chk(rdy, 1'b1);
    wait_al(1'b0, 20);
    chk({alert_n, dnr}, 2'b00);
    $display("Test pin reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
